// *** dv/bbsr_bus_model.sv ***
// behavioural model of the two bus segments seen through the comparators
`default_nettype none

module bbsr_bus_model (
  input  wire logic       link_clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] rise_div,
  input  wire logic [1:0] up_pull,
  input  wire logic [1:0] dn_pull,
  input  wire logic [1:0] channel_join,
  input  wire logic       dclk_out,
  input  wire logic       dclk_oe,
  input  wire logic       ddat_out,
  input  wire logic       ddat_oe,
  output logic      [3:0] line_above_030,
  output logic      [3:0] line_above_041,
  output logic      [3:0] line_above_090
);
  timeunit 1ns;
  timeprecision 100ps;

  // =====================================================================
  // who pulls which line low; an active buffer copies a low across
  logic [1:0] lvl [4];
  logic [3:0] div;
  logic [3:0] own;
  logic [3:0] low;

  assign own = {dn_pull[1] | (dclk_oe & ~dclk_out), dn_pull[0] | (ddat_oe & ~ddat_out), up_pull};
  assign low = {own[3] | (channel_join[1] & own[1]), own[2] | (channel_join[0] & own[0]),
                own[1] | (channel_join[1] & own[3]), own[0] | (channel_join[0] & own[2])};

  // released lines climb one level per rise_div+1 cycles, so slow edges are possible
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      div <= 4'h0;
      for (int i = 0; i < 4; i++) lvl[i] <= 2'h3;
    end else begin
      div <= (div >= rise_div) ? 4'h0 : div + 4'h1;
      for (int i = 0; i < 4; i++) begin
        if (low[i]) lvl[i] <= 2'h0;
        else if (div == 4'h0 && lvl[i] != 2'h3) lvl[i] <= lvl[i] + 2'h1;
      end
    end
  end

  // comparator thresholds in rising order
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line_above_030[i] = (lvl[i] >= 2'h1);
      line_above_041[i] = (lvl[i] >= 2'h2);
      line_above_090[i] = (lvl[i] == 2'h3);
    end
  end
endmodule

`default_nettype wire

// *** dv/bbsr_top_test.sv ***
// self-checking bench for the connection and stuck-bus recovery control
`default_nettype none

module bbsr_top_test;
  timeunit 1ns;
  timeprecision 100ps;

  // =====================================================================
  // shortened counts so the run stays brief
  localparam int STUCK  = 200;
  localparam int SETTLE = 20;
  localparam int HALF   = 8;
  localparam int IDLE   = 10;
  localparam int PULSES = 16;

  logic        clk, link_clk, arst_n, enable;
  logic [3:0]  a30, a41, a90, acc, rise_div;
  logic [1:0]  join_v, up_pull, dn_pull;
  logic        pre, rdy, rdy_oe, dclk, dclk_oe, ddat, ddat_oe;
  logic [7:0]  obs;
  logic [31:0] seed, r;
  int          n_fail, n_compared, n, k;

  assign obs = {join_v[1], acc[2], acc[0], join_v[0], ddat_oe, dclk_oe, pre, rdy_oe};

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // link clock unrelated in phase to the device clock
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  bbsr_top #(.STUCK_CYC(STUCK), .SETTLE_CYC(SETTLE), .HALF_CYC(HALF), .IDLE_CYC(IDLE), .PULSES(PULSES)) DUT (
    .clk(clk), .arst_n(arst_n), .link_clk(link_clk), .enable(enable),
    .line_above_030(a30), .line_above_041(a41), .line_above_090(a90),
    .channel_join(join_v), .rise_accelerator_en(acc), .precharge_en(pre),
    .ready_out(rdy), .ready_oe(rdy_oe),
    .downstream_clock_line_out(dclk), .downstream_clock_line_oe(dclk_oe),
    .downstream_data_line_out(ddat), .downstream_data_line_oe(ddat_oe));

  bbsr_bus_model bus (
    .link_clk(link_clk), .arst_n(arst_n), .rise_div(rise_div), .up_pull(up_pull), .dn_pull(dn_pull),
    .channel_join(join_v), .dclk_out(dclk), .dclk_oe(dclk_oe), .ddat_out(ddat), .ddat_oe(ddat_oe),
    .line_above_030(a30), .line_above_041(a41), .line_above_090(a90));

  // =====================================================================
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // bounded wait for one observed output to reach a level
  task automatic wait_obs(input int b, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (obs[b] !== v && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
  endtask

  task automatic count_rise(input int cyc, output int cnt);
    logic prev;
    cnt = 0;
    prev = dclk_oe;
    repeat (cyc) begin
      @(negedge clk);
      if (dclk_oe === 1'b1 && prev !== 1'b1) cnt++;
      prev = dclk_oe;
    end
  endtask

  task automatic close_out();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, well beyond the expected few thousand cycles
  initial begin
    #(8 * 8000);
    n_fail++;
    close_out();
  end

  // =====================================================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    enable = 1'b0;
    up_pull = 2'h0;
    dn_pull = 2'h0;
    rise_div = 4'h7;
    seed = 32'h631e63de;
    n_fail = 0;
    n_compared = 0;
    repeat (2) @(negedge clk);
    check(32'(obs), 32'h03);
    repeat (18) @(negedge clk);
    arst_n = 1'b1;
    // enable kept low while insertion settles; only this buffer ever enabled
    repeat (60) @(negedge clk);
    check(32'(obs), 32'h03);
    enable = 1'b1;
    wait_obs(0, 1'b0, IDLE + 20, n);
    check(32'(n < IDLE + 20), 32'h1);
    check(32'(pre), 32'h0);

    // slow rising edge on upstream data, copied downstream by the buffer
    up_pull = 2'h1;
    repeat (10) @(negedge clk);
    check(32'(join_v[0]), 32'h1);
    up_pull = 2'h0;
    wait_obs(5, 1'b1, 80, n);
    check(32'(n < 80), 32'h1);
    wait_obs(6, 1'b1, 20, n);
    check(32'(n < 20), 32'h1);
    check(32'(acc[1]), 32'h0);
    wait_obs(5, 1'b0, 80, n);
    check(32'(n < 80), 32'h1);
    check(32'(join_v[0]), 32'h0);

    // slow rising edge on upstream clock: only the two clock accelerators fire
    up_pull = 2'h2;
    repeat (10) @(negedge clk);
    check(32'(join_v[1]), 32'h1);
    up_pull = 2'h0;
    k = 0;
    repeat (40) begin
      @(negedge clk);
      k = k | int'(acc);
    end
    check(32'(k), 32'h0a);
    check(32'(join_v[1]), 32'h0);

    // random upstream traffic with idle gaps keeps the bus alive
    rise_div = 4'h0;
    repeat (30) begin
      r = xs();
      up_pull = r[1:0];
      repeat (int'(r[6:2]) + 1) @(negedge clk);
      up_pull = 2'h0;
      repeat (10) @(negedge clk);
    end
    check(32'(rdy_oe), 32'h0);

    // downstream data stuck, released after three pulses
    dn_pull = 2'h1;
    wait_obs(0, 1'b1, STUCK + 20, n);
    check(32'(n >= STUCK && n <= STUCK + 12), 32'h1);
    repeat (4) @(negedge clk);
    check(32'({join_v, acc}), 32'h0);
    wait_obs(2, 1'b1, SETTLE + 20, n);
    check(32'(n >= SETTLE - 5 && n <= SETTLE + 2), 32'h1);
    wait_obs(2, 1'b0, HALF + 4, n);
    check(32'(n), 32'(HALF));
    repeat (2) begin
      wait_obs(2, 1'b1, HALF + 4, n);
      check(32'(n), 32'(HALF));
      wait_obs(2, 1'b0, HALF + 4, n);
    end
    dn_pull = 2'h0;
    wait_obs(3, 1'b1, HALF + 8, n);
    check(32'(n < HALF + 8), 32'h1);
    check(32'(dclk_oe), 32'h0);
    wait_obs(3, 1'b0, HALF + 4, n);
    check(32'(n), 32'(HALF));
    wait_obs(0, 1'b0, IDLE + 40, n);
    check(32'(n < IDLE + 40), 32'h1);

    // never released: a full train, then nothing more
    dn_pull = 2'h1;
    wait_obs(0, 1'b1, STUCK + 20, n);
    count_rise(SETTLE + 2 * HALF * PULSES + 40, k);
    check(32'(k), 32'(PULSES));

    // enable low stops recovery; its rising edge forces the join
    enable = 1'b0;
    count_rise(STUCK + SETTLE + 60, k);
    check(32'(k), 32'h0);
    check(32'(rdy_oe), 32'h1);
    enable = 1'b1;
    wait_obs(0, 1'b0, 10, n);
    check(32'(n < 10), 32'h1);
    repeat (4) @(negedge clk);
    check(32'(join_v[0]), 32'h1);

    // power up into a stuck bus
    arst_n = 1'b0;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    wait_obs(0, 1'b0, STUCK - 10, n);
    check(32'(n), 32'(STUCK - 10));
    wait_obs(2, 1'b1, SETTLE + 40, n);
    check(32'(n < SETTLE + 40), 32'h1);
    dn_pull = 2'h0;
    // open-drain ready, clock and data pins only ever pull low
    check(32'({rdy, dclk, ddat}), 32'h0);
    close_out();
  end
endmodule

`default_nettype wire

// *** hw/bbsr_params.svh ***
// timing figures and pulse counts for the bus buffer stuck-bus recovery logic
`ifndef BBSR_PARAMS_SVH
`define BBSR_PARAMS_SVH

// =====================================================================
// device clock
`define BBSR_CLK_HZ      125000000

// =====================================================================
// documented intervals, in their own units
`define BBSR_STUCK_MS    45
`define BBSR_SETTLE_US   40
`define BBSR_REC_HZ      5500
`define BBSR_PULSES      16

// bus idle time that counts as a free bus
`define BBSR_IDLE_US     50

// =====================================================================
// line index within the four-bit comparator vectors
`define BBSR_UP_DATA     0
`define BBSR_UP_CLOCK    1
`define BBSR_DN_DATA     2
`define BBSR_DN_CLOCK    3

// counter width, large enough for the longest interval
`define BBSR_TIMER_W     24

`endif

// *** hw/bbsr_pkg.sv ***
// types shared by the bus buffer stuck-bus recovery logic
`default_nettype none

package bbsr_pkg;

  // =====================================================================
  // connection and recovery states
  typedef enum logic [2:0] {
    ST_WAIT,
    ST_JOINED,
    ST_FAULT_WAIT,
    ST_PULSE,
    ST_STOP_A,
    ST_STOP_B
  } bbsr_state_t;

endpackage

`default_nettype wire

// *** hw/bbsr_sync.sv ***
// two flip-flop synchroniser for a group of independent levels
`default_nettype none

module bbsr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // =====================================================================
  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// *** hw/bbsr_timer.sv ***
// reloadable down counter that flags when its interval has run out
`default_nettype none

module bbsr_timer #(
  parameter int             W       = 24,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         restart,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);

  logic [W-1:0] cnt;

  // =====================================================================
  // reload wins; holds at zero once run out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= RST_VAL;
    end else if (restart) begin
      cnt <= load_val;
    end else if (cnt != '0) begin
      cnt <= cnt - W'(1);
    end
  end

  assign expired = (cnt == '0);

endmodule

`default_nettype wire

// *** hw/bbsr_top.sv ***
// connection, accelerator and stuck-bus recovery control of a two-wire bus buffer
//
// How it works
// - joined sides enable all four rise accelerators
// - buffers stay joined until both sides pass 0.3
// - each accelerator starts at its own 0.41 crossing
// - accelerator stops when its line reaches 0.9
// - accelerators off at power-up and during faults
// - fault when downstream lines not both high 45ms
// - on fault: separate sides, pull ready low
// - wait 40us, then up to sixteen 5.5kHz pulses
// - released line ends pulses, then stop condition
// - ready returns high once connection is restored
// - stuck at power-up: never join, recover after timeout
// - precharge active while not connected
// - join only when both sides free, enable high, or on enable rise during fault
// - enable low isolates, ready low, no recovery
// - enable rising edge during fault forces join
`include "bbsr_params.svh"
`default_nettype none

module bbsr_top #(
  parameter int unsigned STUCK_CYC  = (`BBSR_CLK_HZ / 1000) * `BBSR_STUCK_MS,
  parameter int unsigned SETTLE_CYC = ((`BBSR_CLK_HZ / 1000) * `BBSR_SETTLE_US + 999) / 1000,
  parameter int unsigned HALF_CYC   = `BBSR_CLK_HZ / (2 * `BBSR_REC_HZ),
  parameter int unsigned IDLE_CYC   = ((`BBSR_CLK_HZ / 1000) * `BBSR_IDLE_US + 999) / 1000,
  parameter int unsigned PULSES     = `BBSR_PULSES
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       link_clk,
  input  wire logic       enable,
  input  wire logic [3:0] line_above_030,
  input  wire logic [3:0] line_above_041,
  input  wire logic [3:0] line_above_090,
  output logic      [1:0] channel_join,
  output logic      [3:0] rise_accelerator_en,
  output logic            precharge_en,
  output logic            ready_out,
  output logic            ready_oe,
  output logic            downstream_clock_line_out,
  output logic            downstream_clock_line_oe,
  output logic            downstream_data_line_out,
  output logic            downstream_data_line_oe
);

  localparam int TW = `BBSR_TIMER_W;

  // both lines of a pair sit above the low threshold
  function automatic logic pair_high(input logic a, input logic b);
    pair_high = a & b;
  endfunction

  // =====================================================================
  // device clock domain: pin sampling
  logic [4:0] sys_s;

  bbsr_sync #(.W(5)) u_sync_sys (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({enable, line_above_030}),
    .q      (sys_s)
  );

  wire en_s    = sys_s[4];
  wire up_both = pair_high(sys_s[`BBSR_UP_DATA], sys_s[`BBSR_UP_CLOCK]);
  wire dn_both = pair_high(sys_s[`BBSR_DN_DATA], sys_s[`BBSR_DN_CLOCK]);

  // =====================================================================
  // device clock domain: state
  bbsr_pkg::bbsr_state_t state;
  bbsr_pkg::bbsr_state_t next_state;
  logic       en_prev;
  logic       up_dprev;
  logic       dn_dprev;
  logic       up_free;
  logic       dn_free;
  logic       fault;
  logic       conn;
  logic       clk_low;
  logic       next_clk_low;
  logic [4:0] pulse_cnt;
  logic [4:0] next_pulse_cnt;
  logic       up_idle;
  logic       dn_idle;
  logic       stuck_to;
  logic       ph_done;

  // stop = data rising while clock high; idle = both high long enough
  wire en_rise      = en_s & ~en_prev;
  wire up_stop      = up_both & ~up_dprev;
  wire dn_stop      = dn_both & ~dn_dprev;
  wire next_up_free = up_both & (up_free | up_stop | up_idle);
  wire next_dn_free = dn_both & (dn_free | dn_stop | dn_idle);
  wire in_service   = (state == bbsr_pkg::ST_WAIT) | (state == bbsr_pkg::ST_JOINED);

  // =====================================================================
  // interval counters
  bbsr_timer #(.W(TW), .RST_VAL(TW'(IDLE_CYC))) u_idle_up (
    .clk      (clk),
    .arst_n   (arst_n),
    .restart  (~up_both),
    .load_val (TW'(IDLE_CYC)),
    .expired  (up_idle)
  );

  bbsr_timer #(.W(TW), .RST_VAL(TW'(IDLE_CYC))) u_idle_dn (
    .clk      (clk),
    .arst_n   (arst_n),
    .restart  (~dn_both),
    .load_val (TW'(IDLE_CYC)),
    .expired  (dn_idle)
  );

  // reloads whenever downstream is seen fully high; held during recovery
  bbsr_timer #(.W(TW), .RST_VAL(TW'(STUCK_CYC))) u_stuck (
    .clk      (clk),
    .arst_n   (arst_n),
    .restart  (dn_both | ~in_service | en_rise),
    .load_val (TW'(STUCK_CYC)),
    .expired  (stuck_to)
  );

  wire          ph_restart = (next_state != state) | (next_clk_low != clk_low);
  wire [TW-1:0] ph_load    = (next_state == bbsr_pkg::ST_FAULT_WAIT) ? TW'(SETTLE_CYC) : TW'(HALF_CYC - 1);

  bbsr_timer #(.W(TW), .RST_VAL('0)) u_phase (
    .clk      (clk),
    .arst_n   (arst_n),
    .restart  (ph_restart),
    .load_val (ph_load),
    .expired  (ph_done)
  );

  // =====================================================================
  // connection and recovery sequencing
  always_comb begin
    next_state     = state;
    next_clk_low   = clk_low;
    next_pulse_cnt = pulse_cnt;
    case (state)
      bbsr_pkg::ST_WAIT: begin
        if (en_s && up_free && dn_free) begin
          next_state = bbsr_pkg::ST_JOINED;
        end else if (en_rise && fault) begin
          next_state = bbsr_pkg::ST_JOINED;
        end else if (en_s && stuck_to) begin
          next_state = bbsr_pkg::ST_FAULT_WAIT;
        end
      end
      bbsr_pkg::ST_JOINED: begin
        if (!en_s) begin
          next_state = bbsr_pkg::ST_WAIT;
        end else if (stuck_to) begin
          next_state = bbsr_pkg::ST_FAULT_WAIT;
        end
      end
      bbsr_pkg::ST_FAULT_WAIT: begin
        if (!en_s) begin
          next_state = bbsr_pkg::ST_WAIT;
        end else if (ph_done) begin
          next_state     = bbsr_pkg::ST_PULSE;
          next_clk_low   = 1'b1;
          next_pulse_cnt = '0;
        end
      end
      bbsr_pkg::ST_PULSE: begin
        if (!en_s) begin
          next_state = bbsr_pkg::ST_WAIT;
        end else if (!clk_low && dn_both) begin
          next_state = bbsr_pkg::ST_STOP_A;
        end else if (ph_done && clk_low) begin
          next_clk_low = 1'b0;
        end else if (ph_done && pulse_cnt == 5'(PULSES - 1)) begin
          next_state = bbsr_pkg::ST_WAIT;
        end else if (ph_done) begin
          next_clk_low   = 1'b1;
          next_pulse_cnt = pulse_cnt + 5'h01;
        end
      end
      bbsr_pkg::ST_STOP_A: begin
        if (!en_s) begin
          next_state = bbsr_pkg::ST_WAIT;
        end else if (ph_done) begin
          next_state = bbsr_pkg::ST_STOP_B;
        end
      end
      bbsr_pkg::ST_STOP_B: begin
        if (ph_done || !en_s) begin
          next_state = bbsr_pkg::ST_WAIT;
        end
      end
      default: begin
        next_state = bbsr_pkg::ST_WAIT;
      end
    endcase
  end

  // set wins over clear; an enable rise discards the stale timeout
  wire fault_set  = stuck_to & ~en_rise;
  wire fault_clr  = (next_state == bbsr_pkg::ST_JOINED) | ((state == bbsr_pkg::ST_STOP_B) & ph_done);
  wire next_fault = fault_set | (fault & ~fault_clr);

  // state, flags and pin drives all registered together
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= bbsr_pkg::ST_WAIT;
      en_prev   <= 1'b0;
      up_dprev  <= 1'b1;
      dn_dprev  <= 1'b1;
      up_free   <= 1'b0;
      dn_free   <= 1'b0;
      fault     <= 1'b0;
      conn      <= 1'b0;
      clk_low   <= 1'b0;
      pulse_cnt <= '0;
      downstream_clock_line_oe <= 1'b0;
      downstream_data_line_oe  <= 1'b0;
    end else begin
      state     <= next_state;
      en_prev   <= en_s;
      up_dprev  <= sys_s[`BBSR_UP_DATA] | ~sys_s[`BBSR_UP_CLOCK];  // low only for data low under a high clock
      dn_dprev  <= sys_s[`BBSR_DN_DATA] | ~sys_s[`BBSR_DN_CLOCK];
      up_free   <= next_up_free;
      dn_free   <= next_dn_free;
      fault     <= next_fault;
      conn      <= (next_state == bbsr_pkg::ST_JOINED);
      clk_low   <= next_clk_low;
      pulse_cnt <= next_pulse_cnt;
      downstream_clock_line_oe <= (next_state == bbsr_pkg::ST_PULSE) & next_clk_low;
      downstream_data_line_oe  <= (next_state == bbsr_pkg::ST_STOP_A);
    end
  end

  // open-drain pins only ever pull low
  assign ready_out                 = 1'b0;
  assign ready_oe                  = ~conn;
  assign precharge_en              = ~conn;
  assign downstream_clock_line_out = 1'b0;
  assign downstream_data_line_out  = 1'b0;

  // =====================================================================
  // link clock domain: buffers and accelerators
  logic [13:0] lnk_s;
  logic [3:0]  a41_prev;

  // conn and fault are single flops, so each crosses glitch-free
  bbsr_sync #(.W(14)) u_sync_link (
    .clk    (link_clk),
    .arst_n (arst_n),
    .d      ({fault, conn, line_above_090, line_above_041, line_above_030}),
    .q      (lnk_s)
  );

  wire [3:0] a30     = lnk_s[3:0];
  wire [3:0] a41     = lnk_s[7:4];
  wire [3:0] a90     = lnk_s[11:8];
  wire       l_conn  = lnk_s[12];
  wire       l_fault = lnk_s[13];
  wire       acc_ok  = l_conn & ~l_fault;

  // each line starts on its own 0.41 crossing and stops at 0.9 or on a fall
  wire [3:0] next_acc  = {4{acc_ok}} & (rise_accelerator_en | (a41 & ~a41_prev)) & ~a90 & a30;
  wire [1:0] next_join = {2{l_conn}} & ~{pair_high(a30[`BBSR_UP_CLOCK], a30[`BBSR_DN_CLOCK]),
                                         pair_high(a30[`BBSR_UP_DATA], a30[`BBSR_DN_DATA])};

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      a41_prev            <= '1;
      rise_accelerator_en <= '0;
      channel_join        <= '0;
    end else begin
      a41_prev            <= a41;
      rise_accelerator_en <= next_acc;
      channel_join        <= next_join;
    end
  end

  // =====================================================================
  // checks
  a_fault_split: assert property (@(posedge clk) disable iff (!arst_n)
    state == bbsr_pkg::ST_JOINED && en_s && stuck_to |=> state == bbsr_pkg::ST_FAULT_WAIT && ready_oe)
    else $error("fault did not separate the sides");

  a_enable_low: assert property (@(posedge clk) disable iff (!arst_n)
    !en_s |=> !conn && !downstream_clock_line_oe && !downstream_data_line_oe)
    else $error("enable low left connection or recovery active");

  a_settle_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    state == bbsr_pkg::ST_FAULT_WAIT |-> !downstream_clock_line_oe && ready_oe)
    else $error("clock driven during settle wait");

  a_pulse_max: assert property (@(posedge clk) disable iff (!arst_n)
    state == bbsr_pkg::ST_PULSE |-> pulse_cnt < 5'(PULSES))
    else $error("more recovery pulses than allowed");

  a_release_stop: assert property (@(posedge clk) disable iff (!arst_n)
    state == bbsr_pkg::ST_PULSE && en_s && !clk_low && dn_both |=> state == bbsr_pkg::ST_STOP_A ##1
    downstream_data_line_oe && !downstream_clock_line_oe)
    else $error("released bus did not end the burst with a stop");

  a_stop_shape: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(downstream_data_line_oe) |-> !downstream_clock_line_oe && $past(state) == bbsr_pkg::ST_PULSE)
    else $error("stop data low not entered from burst with clock released");

  a_join_cause: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(conn) |-> $past(en_s) && ($past(up_free && dn_free) || $past(fault)))
    else $error("joined without free buses or forced enable");

  a_acc_fault: assert property (@(posedge link_clk) disable iff (!arst_n)
    l_fault |=> rise_accelerator_en == 4'h0)
    else $error("accelerator active during fault");

  a_acc_off90: assert property (@(posedge link_clk) disable iff (!arst_n)
    |a90 |=> (rise_accelerator_en & $past(a90)) == 4'h0)
    else $error("accelerator still on above 0.9");

  a_join_rise: assert property (@(posedge link_clk) disable iff (!arst_n)
    l_conn && !(a30[`BBSR_UP_DATA] && a30[`BBSR_DN_DATA]) |=> channel_join[0])
    else $error("data buffers released before both sides passed 0.3");

endmodule

`default_nettype wire
